// ==== common/hb_pkg.sv ====
// Functional notes
// RULE1: status bits all zero after power-on reset
// RULE2: two-bit per-channel field chosen by priority
// RULE3: each frame returns status of selected group
// RULE4: host resends previous command when reading status
// RULE5: latched faults hold; supply lockout self-recovers
// RULE6: writes accepted during lockout, applied after recovery
// RULE7: overvoltage with lockout enabled forces outputs off
// RULE8: supply recovery restores outputs, clears fault flag
// RULE9: lockout disabled keeps outputs on, flag set
// RULE10: host should keep overvoltage lockout enabled
// RULE11: thermal warning follows sensors, clears itself
// RULE12: thermal warning never changes channel outputs
// RULE13: overtemperature latches channel off, sets pre bit
// RULE14: clear request reopens cooled channels of group
// RULE15: thermal warning reported at status bit 0
// RULE16: field codes 00 off, 01 overcurrent, 10 underload, 11 on
// RULE17: command bits 15 clear, 14 group, 0 lockout
// RULE18: supply fault bit 14, overcurrent bit 15
// RULE19: host spaces clear requests by 150 us
// RULE20: detector levels sampled synchronously before use
package hb_pkg;
	localparam int CHANNELS = 12;
	localparam int GROUP = 6;
	localparam logic [1:0] CMD_ADDR = 2'h0;
	localparam logic [1:0] STATUS_ADDR = 2'h1;
	localparam logic [1:0] FAULT_ADDR = 2'h2;
	localparam int CLEAR_BIT = 15;
	localparam int SELECT_BIT = 14;
	localparam int ENABLE_LO = 7;
	localparam int CONFIG_LO = 1;
	localparam int LOCKOUT_BIT = 0;
	localparam int PRE_BIT = 16;
	localparam int OVERCURRENT_BIT = 15;
	localparam int SUPPLY_FAULT_BIT = 14;
	localparam int UNDERLOAD_BIT = 13;
	localparam int FIELD_LO = 1;
	localparam int WARNING_BIT = 0;
	localparam int FAULT_OVERCURRENT_LO = 12;
	localparam int FAULT_SUPPLY_LO = 24;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [16:0] STATUS_RESET = 17'h00000;
	localparam logic [11:0] LOW_GROUP = 12'h03F;
	localparam logic [1:0] FIELD_OFF = 2'h0;
	localparam logic [1:0] FIELD_OVERCURRENT = 2'h1;
	localparam logic [1:0] FIELD_UNDERLOAD = 2'h2;
	localparam logic [1:0] FIELD_ON = 2'h3;
	localparam time CLEAR_SPACING_US = 150;

	typedef enum logic [1:0] {
		SUPPLY_OK = 2'h0,
		SUPPLY_FLAGGED = 2'h1,
		SUPPLY_LOCKOUT = 2'h3
	} supply_t;

	typedef struct packed {
		logic [1:0] ov;
		logic [1:0] uv;
		logic [11:0] warn;
		logic [11:0] tsd;
		logic [11:0] oc;
		logic [11:0] ul;
	} sample_t;
endpackage

// ==== common/detect_if.sv ====
`timescale 1ns/1ns
interface detect_if;
	hb_pkg::sample_t lv;
	modport sampler (output lv);
	modport core (input lv);
endinterface

// ==== hdl/detector_sampler.sv ====
`timescale 1ns/1ns
module detector_sampler (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] supply_overvoltage,
	input wire logic [1:0] supply_undervoltage,
	input wire logic [11:0] thermal_warn_in,
	input wire logic [11:0] thermal_shutdown_in,
	input wire logic [11:0] overcurrent_in,
	input wire logic [11:0] underload_in,
	detect_if.sampler det
);
	hb_pkg::sample_t next_lv;

	// RULE20: register detector levels
	always_comb
	begin
		next_lv.ov = supply_overvoltage;
		next_lv.uv = supply_undervoltage;
		next_lv.warn = thermal_warn_in;
		next_lv.tsd = thermal_shutdown_in;
		next_lv.oc = overcurrent_in;
		next_lv.ul = underload_in;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			det.lv <= '0;
		else
			det.lv <= next_lv;
	end
endmodule

// ==== hdl/half_bridge_fault_status.sv ====
`timescale 1ns/1ns
module half_bridge_fault_status (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [1:0] supply_overvoltage,
	input wire logic [1:0] supply_undervoltage,
	input wire logic [11:0] thermal_warn_in,
	input wire logic [11:0] thermal_shutdown_in,
	input wire logic [11:0] overcurrent_in,
	input wire logic [11:0] underload_in,
	output logic [11:0] high_side_switch,
	output logic [11:0] low_side_switch,
	output logic supply_fault_flag,
	output logic thermal_warning_flag
);
	typedef struct packed {
		logic [15:0] cmd;
		logic [11:0] en;
		logic [11:0] cnf;
		logic [11:0] tsd;
		logic [11:0] ovc;
		hb_pkg::supply_t supply;
		logic warn;
		logic [16:0] status;
		logic [31:0] rdata;
		logic [11:0] high;
		logic [11:0] low;
	} state_t;

	state_t st;
	state_t next_st;
	detect_if det ();

	detector_sampler u_sampler (
		.clk(clk),
		.rst_n(rst_n),
		.supply_overvoltage(supply_overvoltage),
		.supply_undervoltage(supply_undervoltage),
		.thermal_warn_in(thermal_warn_in),
		.thermal_shutdown_in(thermal_shutdown_in),
		.overcurrent_in(overcurrent_in),
		.underload_in(underload_in),
		.det(det.sampler)
	);

	function automatic logic [11:0] group_mask(input logic sel);
		group_mask = sel ? ~hb_pkg::LOW_GROUP : hb_pkg::LOW_GROUP;
	endfunction

	// RULE2: overcurrent first, then off, underload, on
	// RULE16: fixed two-bit field codes
	function automatic logic [1:0] field_code(input logic oc,
		input logic on, input logic ul);
		if (oc)
			field_code = hb_pkg::FIELD_OVERCURRENT;
		else if (!on)
			field_code = hb_pkg::FIELD_OFF;
		else if (ul)
			field_code = hb_pkg::FIELD_UNDERLOAD;
		else
			field_code = hb_pkg::FIELD_ON;
	endfunction

	logic frame;
	logic supply_bad;
	logic locked;
	logic [11:0] grp_old;
	logic [11:0] grp_new;
	logic [11:0] clr_tsd;
	logic [11:0] clr_ovc;
	logic [11:0] drive;
	logic [16:0] word;

	assign frame = wr && addr == hb_pkg::CMD_ADDR;
	assign supply_bad = |det.lv.ov || |det.lv.uv;
	assign locked = st.supply == hb_pkg::SUPPLY_LOCKOUT;
	assign grp_old = group_mask(st.cmd[hb_pkg::SELECT_BIT]);
	assign grp_new = group_mask(wdata[hb_pkg::SELECT_BIT]);

	always_comb
	begin
		next_st = st;
		clr_tsd = '0;
		clr_ovc = '0;
		word = '0;
		next_st.rdata = '0;
		// RULE5: supply lockout recovers on its own
		case (st.supply)
			hb_pkg::SUPPLY_OK,
			hb_pkg::SUPPLY_FLAGGED,
			hb_pkg::SUPPLY_LOCKOUT:
			begin
				// RULE8: recovery clears the flag
				if (!supply_bad)
					next_st.supply = hb_pkg::SUPPLY_OK;
				// RULE7: lockout on undervoltage, or on overvoltage when enabled
				else if (|det.lv.uv || st.cmd[hb_pkg::LOCKOUT_BIT])
					next_st.supply = hb_pkg::SUPPLY_LOCKOUT;
				// RULE9: flag only, outputs stay on
				else
					next_st.supply = hb_pkg::SUPPLY_FLAGGED;
			end
			default:
				next_st.supply = hb_pkg::SUPPLY_OK;
		endcase
		// RULE11: warning follows sensors
		next_st.warn = |det.lv.warn;
		// RULE14: clear only cooled channels of chosen group
		if (frame && wdata[hb_pkg::CLEAR_BIT])
		begin
			clr_tsd = grp_new & ~det.lv.tsd;
			clr_ovc = grp_new & ~det.lv.oc;
		end
		// RULE13: latch; a new event beats the clear
		next_st.tsd = (st.tsd & ~clr_tsd) | det.lv.tsd;
		next_st.ovc = (st.ovc & ~clr_ovc) | det.lv.oc;
		// RULE3: word for the group picked by prior command
		for (int k = 0; k < hb_pkg::GROUP; k++)
		begin
			if (st.cmd[hb_pkg::SELECT_BIT])
				word[hb_pkg::FIELD_LO + 2 * k +: 2] = field_code(
					st.ovc[k + hb_pkg::GROUP], drive[k + hb_pkg::GROUP],
					det.lv.ul[k + hb_pkg::GROUP]);
			else
				word[hb_pkg::FIELD_LO + 2 * k +: 2] = field_code(
					st.ovc[k], drive[k], det.lv.ul[k]);
		end
		// RULE18: overcurrent and supply fault bits
		word[hb_pkg::OVERCURRENT_BIT] = |(st.ovc & grp_old);
		word[hb_pkg::SUPPLY_FAULT_BIT] = st.supply != hb_pkg::SUPPLY_OK;
		word[hb_pkg::UNDERLOAD_BIT] = |(det.lv.ul & st.en & grp_old);
		// RULE15: global warning at bit 0
		word[hb_pkg::WARNING_BIT] = st.warn;
		// RULE13: shutdown in the pre-frame position
		word[hb_pkg::PRE_BIT] = |st.tsd;
		if (frame)
		begin
			next_st.status = word;
			// RULE17: command word layout
			next_st.cmd = wdata[15:0];
			// RULE6: settings stored even while locked out
			for (int k = 0; k < hb_pkg::GROUP; k++)
			begin
				if (wdata[hb_pkg::SELECT_BIT])
				begin
					next_st.en[k + hb_pkg::GROUP] = wdata[hb_pkg::ENABLE_LO + k];
					next_st.cnf[k + hb_pkg::GROUP] = wdata[hb_pkg::CONFIG_LO + k];
				end
				else
				begin
					next_st.en[k] = wdata[hb_pkg::ENABLE_LO + k];
					next_st.cnf[k] = wdata[hb_pkg::CONFIG_LO + k];
				end
			end
		end
		// RULE12: warning takes no part in the drive terms
		next_st.high = drive & st.cnf;
		next_st.low = drive & ~st.cnf;
		if (rd)
		begin
			case (addr)
				hb_pkg::CMD_ADDR:
					next_st.rdata = {16'h0000, st.cmd};
				hb_pkg::STATUS_ADDR:
					next_st.rdata = {15'h0000, st.status};
				hb_pkg::FAULT_ADDR:
				begin
					next_st.rdata[11:0] = st.tsd;
					next_st.rdata[hb_pkg::FAULT_OVERCURRENT_LO +: 12] = st.ovc;
					next_st.rdata[hb_pkg::FAULT_SUPPLY_LO +: 2] = st.supply;
				end
				default:
					next_st.rdata = '0;
			endcase
		end
	end

	// RULE7: lockout blanks every channel
	assign drive = st.en & ~st.tsd & ~st.ovc & {12{~locked}};

	// RULE1: everything clears at power-on reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.cmd <= hb_pkg::CMD_RESET;
			st.status <= hb_pkg::STATUS_RESET;
			st.supply <= hb_pkg::SUPPLY_OK;
		end
		else
			st <= next_st;
	end

	assign rdata = st.rdata;
	assign high_side_switch = st.high;
	assign low_side_switch = st.low;
	assign supply_fault_flag = st.supply != hb_pkg::SUPPLY_OK;
	assign thermal_warning_flag = st.warn;

	// checking helpers; the status word is only changed by frames
	logic seen_frame;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			seen_frame <= 1'b0;
		else if (frame)
			seen_frame <= 1'b1;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_status_zero_reset: assert property ( // RULE1
		!seen_frame |-> st.status == '0)
		else $error("status nonzero before first frame");

	a_field_priority: assert property ( // RULE2
		frame && !st.cmd[hb_pkg::SELECT_BIT] && st.ovc[0]
		|=> st.status[2:1] == hb_pkg::FIELD_OVERCURRENT)
		else $error("overcurrent field not reported");

	a_group_overcurrent: assert property ( // RULE3
		frame |=> st.status[hb_pkg::OVERCURRENT_BIT] ==
		|($past(st.ovc) & $past(grp_old)))
		else $error("status group mismatch");

	a_lockout_outputs_off: assert property ( // RULE7
		locked |=> high_side_switch == '0 && low_side_switch == '0)
		else $error("outputs on during lockout");

	a_lockout_entry: assert property ( // RULE7
		|det.lv.ov && st.cmd[hb_pkg::LOCKOUT_BIT]
		|=> locked && supply_fault_flag)
		else $error("overvoltage lockout missed");

	a_supply_recover: assert property ( // RULE8
		!supply_bad |=> !supply_fault_flag)
		else $error("supply fault flag stuck");

	a_flag_no_lock: assert property ( // RULE9
		|det.lv.ov && !(|det.lv.uv) && !st.cmd[hb_pkg::LOCKOUT_BIT]
		|=> st.supply == hb_pkg::SUPPLY_FLAGGED)
		else $error("lockout taken while disabled");

	a_warning_follows: assert property ( // RULE11
		|det.lv.warn |=> thermal_warning_flag ##1 (thermal_warning_flag
		|| !$past(|det.lv.warn)))
		else $error("thermal warning not set");

	a_tsd_channel_off: assert property ( // RULE13
		det.lv.tsd[0] |=> st.tsd[0] ##1 !high_side_switch[0]
		&& !low_side_switch[0])
		else $error("overheated channel still driven");

	a_clear_low_group: assert property ( // RULE14
		frame && wdata[hb_pkg::CLEAR_BIT] && !wdata[hb_pkg::SELECT_BIT]
		&& det.lv.tsd == '0 |=> st.tsd[5:0] == '0)
		else $error("clear request ignored");

	a_warning_bit: assert property ( // RULE15
		frame |=> st.status[hb_pkg::WARNING_BIT] == $past(st.warn))
		else $error("warning bit wrong");

	c_lockout: cover property (locked ##1 !locked);
	c_flagged: cover property (st.supply == hb_pkg::SUPPLY_FLAGGED);
	c_clear: cover property (frame && wdata[hb_pkg::CLEAR_BIT] && |st.tsd);
	c_status_read: cover property (rd && addr == hb_pkg::STATUS_ADDR);
endmodule

// ==== test/host_bus.sv ====
`timescale 1ns/1ns
module host_bus (
	input wire logic clk,
	output logic [1:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata
);
	time last_clear = 0;
	initial
	begin
		addr = 2'h0;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic send(input logic [1:0] a, input logic [15:0] c);
		while (c[hb_pkg::CLEAR_BIT] &&
			$time - last_clear < hb_pkg::CLEAR_SPACING_US * 1000)
			@(posedge clk);
		if (c[hb_pkg::CLEAR_BIT])
			last_clear = $time;
		addr <= a;
		wdata <= {16'h0000, c};
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// stale data never looks like a held word
		wdata <= ~wdata;
		// one idle edge so a following request never reassigns wr here
		@(posedge clk);
	endtask
	task automatic fetch(input logic [1:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
endmodule

// ==== test/tb_half_bridge_fault_status.sv ====
`timescale 1ns/1ns
`define CHK(n, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			num_errors++; \
			$display("[ERR] %s exp %0h got %0h", n, e, g); \
		end \
	end
module tb_half_bridge_fault_status;
	logic clk, rst_n, wr, rd, sff, twf;
	logic [1:0] addr, ov, uv;
	logic [31:0] wdata, rdata, st;
	logic [11:0] twarn, tsd, oc, ul, high_sw, low_sw;
	int num_errors = 0;
	int comparisons = 0;
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	host_bus u_host_bus (.clk(clk), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	half_bridge_fault_status u_half_bridge_fault_status (.clk(clk),
		.rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .supply_overvoltage(ov), .supply_undervoltage(uv),
		.thermal_warn_in(twarn), .thermal_shutdown_in(tsd),
		.overcurrent_in(oc), .underload_in(ul), .high_side_switch(high_sw),
		.low_side_switch(low_sw), .supply_fault_flag(sff),
		.thermal_warning_flag(twf));
	function automatic logic [15:0] mk(input logic clr, input logic grp,
		input logic [5:0] en, input logic [5:0] cnf, input logic lock);
		return {clr, grp, 1'b0, en, cnf, lock};
	endfunction
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic poll(input logic [15:0] c);
		u_host_bus.send(hb_pkg::CMD_ADDR, c);
		idle(4);
		u_host_bus.send(hb_pkg::CMD_ADDR, c);
		u_host_bus.fetch(hb_pkg::STATUS_ADDR, st);
	endtask
	task automatic t_reset;
		`CHK("high_sw", 12'h000, high_sw);
		`CHK("flags", 2'b00, {sff, twf});
		u_host_bus.fetch(hb_pkg::STATUS_ADDR, st);
		`CHK("status", 32'h00000000, st);
		u_host_bus.fetch(2'h3, st);
		`CHK("unmapped", 32'h00000000, st);
	endtask
	task automatic t_enable;
		poll(mk(1'b0, 1'b0, 6'h0F, 6'h05, 1'b1));
		`CHK("status", 32'h000001FE, st);
		`CHK("high_sw", 6'h05, high_sw[5:0]);
		`CHK("low_sw", 6'h0A, low_sw[5:0]);
		u_host_bus.fetch(hb_pkg::CMD_ADDR, st);
		`CHK("command", 32'h0000078B, st);
		u_host_bus.send(hb_pkg::STATUS_ADDR, 16'h7FFF);
		u_host_bus.fetch(hb_pkg::STATUS_ADDR, st);
		`CHK("status_kept", 32'h000001FE, st);
	endtask
	task automatic t_ov_lock;
		ov <= 2'b10;
		idle(4);
		`CHK("high_sw", 12'h000, high_sw);
		`CHK("sff", 1'b1, sff);
		poll(mk(1'b0, 1'b0, 6'h3F, 6'h3F, 1'b1));
		`CHK("status", 32'h00004000, st);
		`CHK("high_sw", 12'h000, high_sw);
		ov <= 2'b00;
		idle(4);
		`CHK("high_sw", 6'h3F, high_sw[5:0]);
		`CHK("sff", 1'b0, sff);
		uv <= 2'b01;
		idle(4);
		`CHK("high_sw", 12'h000, high_sw);
		`CHK("sff", 1'b1, sff);
		uv <= 2'b00;
		idle(4);
		`CHK("high_sw", 6'h3F, high_sw[5:0]);
	endtask
	task automatic t_ov_free;
		u_host_bus.send(hb_pkg::CMD_ADDR, mk(1'b0, 1'b0, 6'h3F, 6'h3F, 1'b0));
		ov <= 2'b01;
		idle(4);
		`CHK("high_sw", 6'h3F, high_sw[5:0]);
		`CHK("sff", 1'b1, sff);
		ov <= 2'b00;
		u_host_bus.send(hb_pkg::CMD_ADDR, mk(1'b0, 1'b0, 6'h3F, 6'h3F, 1'b1));
		idle(4);
		`CHK("sff", 1'b0, sff);
	endtask
	task automatic t_thermal;
		twarn <= 12'h004;
		idle(4);
		`CHK("twf", 1'b1, twf);
		`CHK("high_sw", 6'h3F, high_sw[5:0]);
		poll(mk(1'b0, 1'b0, 6'h3F, 6'h3F, 1'b1));
		`CHK("status", 32'h00001FFF, st);
		tsd <= 12'h004;
		idle(4);
		`CHK("high_sw", 6'h3B, high_sw[5:0]);
		`CHK("low2", 1'b0, low_sw[2]);
		`CHK("twf", 1'b1, twf);
		u_host_bus.fetch(hb_pkg::FAULT_ADDR, st);
		`CHK("fault_view", 32'h00000004, st);
		poll(mk(1'b0, 1'b0, 6'h3F, 6'h3F, 1'b1));
		`CHK("status", 32'h00011F9F, st);
		tsd <= 12'h000;
		twarn <= 12'h000;
		idle(4);
		`CHK("twf", 1'b0, twf);
		u_host_bus.send(hb_pkg::CMD_ADDR, mk(1'b1, 1'b1, 6'h00, 6'h00, 1'b1));
		idle(4);
		`CHK("high_sw", 6'h3B, high_sw[5:0]);
		u_host_bus.send(hb_pkg::CMD_ADDR, mk(1'b1, 1'b0, 6'h3F, 6'h3F, 1'b1));
		idle(4);
		`CHK("high_sw", 6'h3F, high_sw[5:0]);
		poll(mk(1'b0, 1'b0, 6'h3F, 6'h3F, 1'b1));
		`CHK("status", 32'h00001FFE, st);
	endtask
	task automatic t_codes;
		oc <= 12'h040;
		ul <= 12'h080;
		idle(3);
		poll(mk(1'b0, 1'b1, 6'h3F, 6'h3F, 1'b1));
		`CHK("status", 32'h0000BFF2, st);
		`CHK("high_sw", 6'h3E, high_sw[11:6]);
		oc <= 12'h000;
		ul <= 12'h000;
		idle(3);
		u_host_bus.send(hb_pkg::CMD_ADDR, mk(1'b1, 1'b1, 6'h3F, 6'h3F, 1'b1));
		idle(4);
		`CHK("high_sw", 6'h3F, high_sw[11:6]);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'b0;
		ov = 2'b00;
		uv = 2'b00;
		twarn = 12'h000;
		tsd = 12'h000;
		oc = 12'h000;
		ul = 12'h000;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset;
		t_enable;
		t_ov_lock;
		t_ov_free;
		t_thermal;
		t_codes;
		give_verdict;
	end
	// clear spacing dominates the run, about 4500 cycles
	initial
	begin
		#2000000;
		num_errors++;
		give_verdict;
	end
endmodule
